// [logic/tmr3_pkg.sv]
// constants, register map and field layout of the third timer
// assumes a 4-bit register address space and 8-bit register data
package tmr3_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;

	// register offsets
	localparam logic [3:0] ADDR_MODE    = 4'h0;
	localparam logic [3:0] ADDR_CTRL    = 4'h1;
	localparam logic [3:0] ADDR_CLKSEL  = 4'h2;
	localparam logic [3:0] ADDR_CMODE1  = 4'h3;
	localparam logic [3:0] ADDR_CMODE2  = 4'h4;
	localparam logic [3:0] ADDR_CMP1    = 4'h5;
	localparam logic [3:0] ADDR_CMP2    = 4'h6;
	localparam logic [3:0] ADDR_CAPTURE = 4'h7;
	localparam logic [3:0] ADDR_STATUS  = 4'h8;

	// mode codes
	localparam logic [3:0] MODE_TIMER     = 4'hf;
	localparam logic [3:0] MODE_EXT_TRIG  = 4'he;
	localparam logic [3:0] MODE_INT_TRIG  = 4'hd;
	localparam logic [3:0] MODE_TIMER_T2O = 4'hc;
	localparam logic [3:0] MODE_TRIG_T2O  = 4'hb;
	localparam logic [3:0] MODE_BURST_M2  = 4'ha;
	localparam logic [3:0] MODE_BURST_SO  = 4'h9;
	localparam logic [3:0] MODE_FSK       = 4'h8;
	localparam logic [3:0] MODE_PWM       = 4'h7;

	// control fields
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_PRESET = 1;
	localparam int CTRL_EIM    = 3;
	// clock-select fields
	localparam int CLK_EXT     = 0;
	localparam int CLK_EDGE_LO = 1;
	localparam int CLK_EDGE_HI = 2;
	// compare-mode fields
	localparam int CM_RESET  = 0;
	localparam int CM_IRQ    = 1;
	localparam int CM_TOGGLE = 2;
	localparam int CM_SINGLE = 3;
	// status fields
	localparam int ST_RUN  = 0;
	localparam int ST_CM1  = 1;
	localparam int ST_CM2  = 2;
	localparam int ST_EDGE = 3;

	// edge select codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// reset values
	localparam logic [3:0] MODE_RST = 4'hf;
	localparam logic [7:0] CMP_RST  = 8'hff;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT} run_state_t;
endpackage

// [logic/edge_if.sv]
// carries the input edge stage settings and results to the timer core
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface edge_if;
	logic [1:0] edge_sel;
	logic       pin_level;
	logic       edge_pulse;
	modport stage (input edge_sel, output pin_level, output edge_pulse);
	modport user  (output edge_sel, input pin_level, input edge_pulse);
endinterface

// [logic/input_edge_stage.sv]
// synchroniser and programmable edge detector for the external timer input
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
module input_edge_stage (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic timer_input_pin,
	edge_if.stage     eif
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic last_q, last_d;
	logic pulse_q, pulse_d;

	always_comb begin
		meta_d = timer_input_pin;
		sync_d = meta_q;
		last_d = sync_q;
		unique case (eif.edge_sel)
			tmr3_pkg::EDGE_RISE: pulse_d = sync_q & ~last_q;
			tmr3_pkg::EDGE_FALL: pulse_d = ~sync_q & last_q;
			tmr3_pkg::EDGE_BOTH: pulse_d = sync_q ^ last_q;
			tmr3_pkg::EDGE_NONE: pulse_d = 1'b0;
		endcase
	end

	// only the second and third stages are looked at; the first may be metastable
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_q  <= 1'b0;
			sync_q  <= 1'b0;
			last_q  <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			meta_q  <= meta_d;
			sync_q  <= sync_d;
			last_q  <= last_d;
			pulse_q <= pulse_d;
		end
	end

	assign eif.pin_level  = last_q;
	assign eif.edge_pulse = pulse_q;
endmodule

// [logic/timer3_counter_modulator.sv]
// third timer: 8-bit counter with two compares, capture and modulator output
// assumes a same-clock register port, prescaler tick and second timer / serial signals
`timescale 1ns/1ps
module timer3_counter_modulator #(
	parameter int CNT_W = 8
) (
	input  wire logic                        ref_clk,
	input  wire logic                        srst,
	input  wire logic [tmr3_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [tmr3_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [tmr3_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        timer_input_pin,
	input  wire logic                        int_clk_tick,
	input  wire logic                        second_timer_toggle,
	input  wire logic                        second_timer_output,
	input  wire logic                        second_timer_output_flipflop,
	input  wire logic                        serial_shift_data,
	output logic                             timer_output_pin,
	output logic                             third_timer_toggle,
	output logic                             timer_irq
);
	generate
		if (CNT_W != tmr3_pkg::DATA_W) begin : g_bad_width
			$error("counter width must equal register data width");
		end
	endgenerate

	edge_if eif ();

	input_edge_stage u_edge (
		.ref_clk         (ref_clk),
		.srst            (srst),
		.timer_input_pin (timer_input_pin),
		.eif             (eif)
	);

	logic [3:0]       timer_three_mode_select_q, timer_three_mode_select_d;
	logic [3:0]       timer_three_control_q, timer_three_control_d;
	logic [2:0]       clksel_q, clksel_d;
	logic [3:0]       cmode1_q, cmode1_d;
	logic [3:0]       cmode2_q, cmode2_d;
	logic [CNT_W-1:0] compare_reg_one_q, compare_reg_one_d;
	logic [CNT_W-1:0] compare_reg_two_q, compare_reg_two_d;
	logic [CNT_W-1:0] capture_q, capture_d;
	logic [3:0]       timer_status_reg_q, timer_status_reg_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	tmr3_pkg::run_state_t state_q, state_d;
	logic             sel_q, sel_d;
	logic             done1_q, done1_d;
	logic             done2_q, done2_d;
	logic             tog_q, tog_d;
	logic             out_q, out_d;
	logic             tog_ev_q, tog_ev_d;
	logic             irq_q, irq_d;
	logic [7:0]       rdata_q, rdata_d;

	logic             run_bit;
	logic             tick;
	logic             ext_trig_mode;
	logic             trig_ev;
	logic             active_sel;
	logic [3:0]       act_mode;
	logic [CNT_W-1:0] act_cmp;
	logic             act_done;
	logic             match;
	logic             edge_irq;

	function automatic logic mode_legal(input logic [3:0] m);
		return m >= tmr3_pkg::MODE_PWM;
	endfunction

	function automatic logic is_ext_trig(input logic [3:0] m);
		return (m == tmr3_pkg::MODE_EXT_TRIG) || (m == tmr3_pkg::MODE_TRIG_T2O);
	endfunction

	assign eif.edge_sel = clksel_q[tmr3_pkg::CLK_EDGE_HI:tmr3_pkg::CLK_EDGE_LO];
	assign run_bit      = timer_three_control_q[tmr3_pkg::CTRL_RUN];
	assign ext_trig_mode = is_ext_trig(timer_three_mode_select_q);

	// external trigger modes always count the internal clock, the input is the trigger
	always_comb begin
		if (clksel_q[tmr3_pkg::CLK_EXT] && !ext_trig_mode) begin
			tick = eif.edge_pulse;
		end else begin
			tick = int_clk_tick;
		end
	end

	// restart events: input edge in modes 2/5, second timer toggle in 3 and 9
	always_comb begin
		trig_ev = 1'b0;
		if (state_q == tmr3_pkg::ST_COUNT) begin
			if (ext_trig_mode) begin
				trig_ev = eif.edge_pulse;
			end else if (timer_three_mode_select_q == tmr3_pkg::MODE_INT_TRIG
				|| timer_three_mode_select_q == tmr3_pkg::MODE_PWM) begin
				trig_ev = second_timer_toggle;
			end
		end
	end

	// FSK and PWM let the serial data pick the register
	always_comb begin
		if (timer_three_mode_select_q == tmr3_pkg::MODE_FSK
			|| timer_three_mode_select_q == tmr3_pkg::MODE_PWM) begin
			active_sel = serial_shift_data;
		end else begin
			active_sel = sel_q;
		end
		act_mode = active_sel ? cmode2_q : cmode1_q;
		act_cmp  = active_sel ? compare_reg_two_q : compare_reg_one_q;
		act_done = active_sel ? done2_q : done1_q;
	end

	// count value x matches on its (x+1)th tick from zero
	assign match = (state_q == tmr3_pkg::ST_COUNT) && tick && !trig_ev
		&& (cnt_q == act_cmp) && !(act_mode[tmr3_pkg::CM_SINGLE] && act_done);

	assign edge_irq = eif.edge_pulse && timer_three_control_q[tmr3_pkg::CTRL_EIM]
		&& !run_bit;

	// sequencing: state, counter, compare selection and single-action flags
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		sel_d   = sel_q;
		done1_d = done1_q;
		done2_d = done2_q;
		if (!run_bit || !mode_legal(timer_three_mode_select_q)) begin
			state_d = tmr3_pkg::ST_IDLE;
			cnt_d   = '0;
			sel_d   = 1'b0;
			done1_d = 1'b0;
			done2_d = 1'b0;
		end else begin
			unique case (state_q)
				tmr3_pkg::ST_IDLE: begin
					state_d = ext_trig_mode ? tmr3_pkg::ST_ARMED : tmr3_pkg::ST_COUNT;
				end
				tmr3_pkg::ST_ARMED: begin
					if (eif.edge_pulse) begin
						state_d = tmr3_pkg::ST_COUNT;
					end
				end
				tmr3_pkg::ST_COUNT: begin
					if (trig_ev) begin
						cnt_d   = '0;
						sel_d   = 1'b0;
						done1_d = 1'b0;
						done2_d = 1'b0;
					end else if (tick) begin
						if (match && act_mode[tmr3_pkg::CM_RESET]) begin
							cnt_d = '0;
						end else begin
							cnt_d = cnt_q + 1'b1;
						end
					end
					if (match) begin
						if (active_sel) begin
							done2_d = cmode2_q[tmr3_pkg::CM_SINGLE];
							sel_d   = !(cmode1_q[tmr3_pkg::CM_SINGLE] && done1_q);
						end else begin
							done1_d = cmode1_q[tmr3_pkg::CM_SINGLE];
							sel_d   = cmode2_q[tmr3_pkg::CM_SINGLE] && done2_q ? 1'b0 : 1'b1;
						end
					end else if (!trig_ev && tick && act_mode[tmr3_pkg::CM_SINGLE] && act_done
						&& !(active_sel ? cmode1_q[tmr3_pkg::CM_SINGLE] && done1_q
						: cmode2_q[tmr3_pkg::CM_SINGLE] && done2_q)) begin
						sel_d = ~sel_q;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q <= tmr3_pkg::ST_IDLE;
			cnt_q   <= '0;
			sel_q   <= 1'b0;
			done1_q <= 1'b0;
			done2_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			sel_q   <= sel_d;
			done1_q <= done1_d;
			done2_q <= done2_d;
		end
	end

	// output stage: toggle flip-flop, pin mux, event pulses
	always_comb begin
		tog_d    = tog_q;
		tog_ev_d = 1'b0;
		irq_d    = 1'b0;
		if (reg_wr && reg_addr == tmr3_pkg::ADDR_CTRL && !run_bit) begin
			tog_d = reg_wdata[tmr3_pkg::CTRL_PRESET];
		end else if (match && act_mode[tmr3_pkg::CM_TOGGLE]) begin
			tog_d    = ~tog_q;
			tog_ev_d = 1'b1;
		end
		if ((match && act_mode[tmr3_pkg::CM_IRQ]) || edge_irq) begin
			irq_d = 1'b1;
		end
		unique case (timer_three_mode_select_q)
			tmr3_pkg::MODE_TIMER_T2O,
			tmr3_pkg::MODE_TRIG_T2O: out_d = second_timer_output;
			tmr3_pkg::MODE_BURST_M2: out_d = tog_q & second_timer_output_flipflop;
			tmr3_pkg::MODE_BURST_SO: out_d = tog_q & serial_shift_data;
			default:                 out_d = tog_q;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tog_q    <= 1'b0;
			tog_ev_q <= 1'b0;
			irq_q    <= 1'b0;
			out_q    <= 1'b0;
		end else begin
			tog_q    <= tog_d;
			tog_ev_q <= tog_ev_d;
			irq_q    <= irq_d;
			out_q    <= out_d;
		end
	end

	assign timer_output_pin   = out_q;
	assign third_timer_toggle = tog_ev_q;
	assign timer_irq          = irq_q;

	// register file; compare and edge status flags clear on read (the run flag follows the state), but a new event in that cycle wins
	always_comb begin
		timer_three_mode_select_d = timer_three_mode_select_q;
		timer_three_control_d     = timer_three_control_q;
		clksel_d                  = clksel_q;
		cmode1_d                  = cmode1_q;
		cmode2_d                  = cmode2_q;
		compare_reg_one_d         = compare_reg_one_q;
		compare_reg_two_d         = compare_reg_two_q;
		if (reg_wr) begin
			unique case (reg_addr)
				tmr3_pkg::ADDR_MODE:   timer_three_mode_select_d = reg_wdata[3:0];
				tmr3_pkg::ADDR_CTRL:   timer_three_control_d     = reg_wdata[3:0];
				tmr3_pkg::ADDR_CLKSEL: clksel_d                  = reg_wdata[2:0];
				tmr3_pkg::ADDR_CMODE1: cmode1_d                  = reg_wdata[3:0];
				tmr3_pkg::ADDR_CMODE2: cmode2_d                  = reg_wdata[3:0];
				tmr3_pkg::ADDR_CMP1:   compare_reg_one_d         = reg_wdata;
				tmr3_pkg::ADDR_CMP2:   compare_reg_two_d         = reg_wdata;
				default: ;
			endcase
		end
		// capture modes load the count into the capture on a restart event and hold it; elsewhere it follows the live count
		if (timer_three_mode_select_q == tmr3_pkg::MODE_INT_TRIG || ext_trig_mode) begin
			capture_d = trig_ev ? cnt_q : capture_q;
		end else begin
			capture_d = cnt_q;
		end
		timer_status_reg_d = timer_status_reg_q;
		if (reg_rd && reg_addr == tmr3_pkg::ADDR_STATUS) begin
			timer_status_reg_d = '0;
		end
		timer_status_reg_d[tmr3_pkg::ST_RUN] = (state_q != tmr3_pkg::ST_IDLE);
		if (match && !active_sel) begin
			timer_status_reg_d[tmr3_pkg::ST_CM1] = 1'b1;
		end
		if (match && active_sel) begin
			timer_status_reg_d[tmr3_pkg::ST_CM2] = 1'b1;
		end
		if (eif.edge_pulse) begin
			timer_status_reg_d[tmr3_pkg::ST_EDGE] = 1'b1;
		end
		rdata_d = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				tmr3_pkg::ADDR_MODE:    rdata_d = {4'h0, timer_three_mode_select_q};
				tmr3_pkg::ADDR_CTRL:    rdata_d = {4'h0, timer_three_control_q};
				tmr3_pkg::ADDR_CLKSEL:  rdata_d = {5'h00, clksel_q};
				tmr3_pkg::ADDR_CMODE1:  rdata_d = {4'h0, cmode1_q};
				tmr3_pkg::ADDR_CMODE2:  rdata_d = {4'h0, cmode2_q};
				tmr3_pkg::ADDR_CMP1:    rdata_d = compare_reg_one_q;
				tmr3_pkg::ADDR_CMP2:    rdata_d = compare_reg_two_q;
				tmr3_pkg::ADDR_CAPTURE: rdata_d = capture_q;
				tmr3_pkg::ADDR_STATUS:  rdata_d = {4'h0, timer_status_reg_q};
				default:                rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timer_three_mode_select_q <= tmr3_pkg::MODE_RST;
			timer_three_control_q     <= '0;
			clksel_q                  <= '0;
			cmode1_q                  <= '0;
			cmode2_q                  <= '0;
			compare_reg_one_q         <= tmr3_pkg::CMP_RST;
			compare_reg_two_q         <= tmr3_pkg::CMP_RST;
			capture_q                 <= '0;
			timer_status_reg_q        <= '0;
			rdata_q                   <= '0;
		end else begin
			timer_three_mode_select_q <= timer_three_mode_select_d;
			timer_three_control_q     <= timer_three_control_d;
			clksel_q                  <= clksel_d;
			cmode1_q                  <= cmode1_d;
			cmode2_q                  <= cmode2_d;
			compare_reg_one_q         <= compare_reg_one_d;
			compare_reg_two_q         <= compare_reg_two_d;
			capture_q                 <= capture_d;
			timer_status_reg_q        <= timer_status_reg_d;
			rdata_q                   <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	property p_match_value;
		@(posedge ref_clk) disable iff (srst)
		match |-> cnt_q == act_cmp;
	endproperty
	a_match_value: assert property (p_match_value) else $error("match off value");

	property p_wrap;
		@(posedge ref_clk) disable iff (srst)
		(state_q == tmr3_pkg::ST_COUNT && run_bit && tick && !trig_ev && !match
			&& cnt_q == 8'hff && mode_legal(timer_three_mode_select_q))
		|=> cnt_q == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_armed_hold;
		@(posedge ref_clk) disable iff (srst)
		(state_q == tmr3_pkg::ST_ARMED && !eif.edge_pulse && run_bit) |=> cnt_q == 8'h00;
	endproperty
	a_armed_hold: assert property (p_armed_hold) else $error("armed counter moved");

	property p_single_once;
		@(posedge ref_clk) disable iff (srst)
		(done1_q && cmode1_q[tmr3_pkg::CM_SINGLE] && !trig_ev) |-> !(match && !active_sel);
	endproperty
	a_single_once: assert property (p_single_once) else $error("single action repeated");

	property p_alternate;
		@(posedge ref_clk) disable iff (srst)
		(match && !active_sel && cmode1_q == 4'h0 && cmode2_q == 4'h0 && run_bit
			&& timer_three_mode_select_q == tmr3_pkg::MODE_TIMER) |=> sel_q;
	endproperty
	a_alternate: assert property (p_alternate) else $error("compare not alternated");

	property p_edge_irq;
		@(posedge ref_clk) disable iff (srst)
		(eif.edge_pulse && run_bit && !(match && act_mode[tmr3_pkg::CM_IRQ])) |=> !timer_irq;
	endproperty
	a_edge_irq: assert property (p_edge_irq) else $error("edge irq while running");

	property p_capture;
		@(posedge ref_clk) disable iff (srst)
		(trig_ev && timer_three_mode_select_q == tmr3_pkg::MODE_INT_TRIG)
		|=> capture_q == $past(cnt_q) && cnt_q == 8'h00;
	endproperty
	a_capture: assert property (p_capture) else $error("capture or reset missed");

	property p_burst_gate;
		@(posedge ref_clk) disable iff (srst)
		(timer_three_mode_select_q == tmr3_pkg::MODE_BURST_SO && !serial_shift_data)
		|=> !timer_output_pin;
	endproperty
	a_burst_gate: assert property (p_burst_gate) else $error("burst not gated");

	property p_status_cm;
		@(posedge ref_clk) disable iff (srst)
		(match && !active_sel) |=> timer_status_reg_q[tmr3_pkg::ST_CM1];
	endproperty
	a_status_cm: assert property (p_status_cm) else $error("status lost compare");
endmodule

// [test/far_side_model.sv]
// far-side model: second timer, serial shift data output and timer input pin
// assumes the timer samples every one of these inputs on rising ref_clk
`timescale 1ns/1ps
module far_side_model (
	input  wire logic ref_clk,
	output logic      int_clk_tick,
	output logic      second_timer_toggle,
	output logic      second_timer_output,
	output logic      second_timer_output_flipflop,
	output logic      serial_shift_data,
	output logic      timer_input_pin
);
	initial begin
		int_clk_tick = 1'b0;
		second_timer_toggle = 1'b0;
		second_timer_output = 1'b0;
		second_timer_output_flipflop = 1'b0;
		serial_shift_data = 1'b0;
		timer_input_pin = 1'b0;
	end
	// ticks two cycles apart so every one is a separate one-cycle pulse
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			int_clk_tick <= 1'b1;
			@(posedge ref_clk);
			int_clk_tick <= 1'b0;
		end
	endtask
	// the second timer's toggle event doubles as this timer's restart
	task automatic toggle();
		@(posedge ref_clk);
		second_timer_toggle <= 1'b1;
		second_timer_output_flipflop <= ~second_timer_output_flipflop;
		@(posedge ref_clk);
		second_timer_toggle <= 1'b0;
	endtask
	task automatic serial(input logic v);
		@(posedge ref_clk);
		serial_shift_data <= v;
	endtask
	task automatic level(input logic v);
		@(posedge ref_clk);
		second_timer_output <= v;
	endtask
	// the pin needs three cycles through the synchroniser, so allow six
	task automatic pin(input logic v);
		@(posedge ref_clk);
		timer_input_pin <= v;
		repeat (6) @(posedge ref_clk);
	endtask
endmodule

// [test/testbench.sv]
// self-checking bench for the third timer
// assumes far_side_model drives the second timer, serial and pin inputs
`timescale 1ns/1ps
module testbench;
	logic       ref_clk;
	logic       srst;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       tick, tog, t2o, m2, sdata, tpin;
	logic       timer_output_pin;
	logic       third_timer_toggle;
	logic       timer_irq;
	logic [7:0] exp_q[$];
	logic       rd_seen;
	logic [7:0] d;
	int         n_mismatch, n_compared, n_irq, base, seed, n, n_tog, tbase;

	timer3_counter_modulator timer3_counter_modulator_i (
		.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_input_pin(tpin), .int_clk_tick(tick), .second_timer_toggle(tog),
		.second_timer_output(t2o), .second_timer_output_flipflop(m2),
		.serial_shift_data(sdata), .timer_output_pin(timer_output_pin),
		.third_timer_toggle(third_timer_toggle), .timer_irq(timer_irq)
	);
	far_side_model far_side_model_i (
		.ref_clk(ref_clk), .int_clk_tick(tick), .second_timer_toggle(tog),
		.second_timer_output(t2o), .second_timer_output_flipflop(m2),
		.serial_shift_data(sdata), .timer_input_pin(tpin)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// read data stand only in the cycle after the strobe, so look there
	always @(posedge ref_clk) begin
		if (rd_seen === 1'b1)
			chk(reg_rdata, exp_q.pop_front());
		if (timer_irq === 1'b1)
			n_irq++;
		if (third_timer_toggle === 1'b1)
			n_tog++;
		rd_seen <= reg_rd;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] v);
		exp_q.push_back(v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic rst();
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		base = n_irq;
		tbase = n_tog;
	endtask
	task automatic run_ticks(input logic [3:0] mode, input int k);
		wr(tmr3_pkg::ADDR_MODE, {4'h0, mode});
		wr(tmr3_pkg::ADDR_CTRL, 8'h01);
		repeat (4) @(posedge ref_clk);
		far_side_model_i.ticks(k);
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		seed = 32'hd976;
		srst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rd_seen = 1'b0;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		rd(tmr3_pkg::ADDR_MODE, 8'h0f);
		rd(tmr3_pkg::ADDR_CTRL, 8'h00);
		rd(tmr3_pkg::ADDR_CMP1, 8'hff);
		rd(tmr3_pkg::ADDR_CMP2, 8'hff);
		rd(tmr3_pkg::ADDR_STATUS, 8'h00);
		rd(4'hf, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			wr(tmr3_pkg::ADDR_CMP1 + 4'(i % 2), d);
			rd(tmr3_pkg::ADDR_CMP1 + 4'(i % 2), d);
		end
		// free running past the top: no compare reset enabled
		rst();
		n = 256 + ($random(seed) & 31);
		run_ticks(tmr3_pkg::MODE_TIMER, n);
		rd(tmr3_pkg::ADDR_CAPTURE, 8'(n % 256));
		// compare one, then compare two stays selected: 3 ticks then 5 ticks per period
		rst();
		wr(tmr3_pkg::ADDR_CMP1, 8'h02);
		wr(tmr3_pkg::ADDR_CMP2, 8'h04);
		wr(tmr3_pkg::ADDR_CMODE1, 8'h03);
		wr(tmr3_pkg::ADDR_CMODE2, 8'h03);
		run_ticks(tmr3_pkg::MODE_TIMER, 10);
		rd(tmr3_pkg::ADDR_CAPTURE, 8'h02);
		chk(8'(n_irq - base), 8'h02);
		rd(tmr3_pkg::ADDR_STATUS, 8'h07);
		rd(tmr3_pkg::ADDR_STATUS, 8'h01);
		// single action on compare one: afterwards only compare two
		rst();
		wr(tmr3_pkg::ADDR_CMP1, 8'h02);
		wr(tmr3_pkg::ADDR_CMP2, 8'h04);
		wr(tmr3_pkg::ADDR_CMODE1, 8'h0b);
		wr(tmr3_pkg::ADDR_CMODE2, 8'h03);
		run_ticks(tmr3_pkg::MODE_TIMER, 14);
		rd(tmr3_pkg::ADDR_CAPTURE, 8'h01);
		chk(8'(n_irq - base), 8'h03);
		// input edge interrupt only while stopped and masked in
		rst();
		wr(tmr3_pkg::ADDR_CTRL, 8'h08);
		wr(tmr3_pkg::ADDR_CLKSEL, 8'h02);
		far_side_model_i.pin(1'b1);
		far_side_model_i.pin(1'b0);
		chk(8'(n_irq - base), 8'h01);
		rd(tmr3_pkg::ADDR_STATUS, 8'h08);
		wr(tmr3_pkg::ADDR_CTRL, 8'h09);
		far_side_model_i.pin(1'b1);
		chk(8'(n_irq - base), 8'h01);
		// external trigger: armed, start on edge, capture on next edge
		rst();
		wr(tmr3_pkg::ADDR_CLKSEL, 8'h02);
		run_ticks(tmr3_pkg::MODE_EXT_TRIG, 4);
		far_side_model_i.pin(1'b0);
		far_side_model_i.pin(1'b1);
		far_side_model_i.ticks(5);
		far_side_model_i.pin(1'b0);
		far_side_model_i.pin(1'b1);
		rd(tmr3_pkg::ADDR_CAPTURE, 8'h05);
		// second timer toggle captures the count then restarts
		rst();
		run_ticks(tmr3_pkg::MODE_INT_TRIG, 7);
		far_side_model_i.toggle();
		far_side_model_i.ticks(2);
		repeat (4) @(posedge ref_clk);
		rd(tmr3_pkg::ADDR_CAPTURE, 8'h07);
		// output pin carries the second timer output
		rst();
		run_ticks(tmr3_pkg::MODE_TIMER_T2O, 1);
		far_side_model_i.level(1'b1);
		repeat (4) @(posedge ref_clk);
		chk({7'h0, timer_output_pin}, 8'h01);
		far_side_model_i.level(1'b0);
		repeat (4) @(posedge ref_clk);
		chk({7'h0, timer_output_pin}, 8'h00);
		// serial data gates the own carrier; one match toggles once
		rst();
		wr(tmr3_pkg::ADDR_CMP1, 8'h01);
		wr(tmr3_pkg::ADDR_CMP2, 8'h01);
		wr(tmr3_pkg::ADDR_CMODE1, 8'h05);
		wr(tmr3_pkg::ADDR_CMODE2, 8'h05);
		far_side_model_i.serial(1'b0);
		run_ticks(tmr3_pkg::MODE_BURST_SO, 2);
		chk({7'h0, timer_output_pin}, 8'h00);
		chk(8'(n_tog - tbase), 8'h01);
		far_side_model_i.serial(1'b1);
		repeat (3) @(posedge ref_clk);
		chk({7'h0, timer_output_pin}, 8'h01);
		// FSK: serial data high picks compare two
		rst();
		wr(tmr3_pkg::ADDR_CMP1, 8'h05);
		wr(tmr3_pkg::ADDR_CMP2, 8'h01);
		run_ticks(tmr3_pkg::MODE_FSK, 2);
		rd(tmr3_pkg::ADDR_STATUS, 8'h05);
		far_side_model_i.serial(1'b0);
		// a refused mode code keeps the counter idle
		rst();
		run_ticks(4'h3, 5);
		rd(tmr3_pkg::ADDR_CAPTURE, 8'h00);
		give_verdict();
	end
endmodule
